// *** twrp_port.sv ***
// Two-wire serial slave port giving access to control registers
// How it works
// - Bytes travel most significant bit first
// - Write not acknowledged leaves data line high
// - Master no-ack ends read, line released
// - First write byte loads register pointer
// - Writes start at base, pointer then advances
// - Pointer holds at top register 14h
// - Base address above 14h not acknowledged
// - Read starts at previously written base
// - Pointer advances after each byte read
// - Stop condition ends the transaction
// - Repeated start accepted without stop
// - Address is 10011 plus select pins
// - Start is data falling while clock high
// - Address match pulls data low ninth pulse
// - Address mismatch stays silent
`timescale 1ns/1ps
`default_nettype none
module twrp_port
  import twrp_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  // Address select straps
  input  wire logic [1:0] slave_addr_select_pins,
  // Register file side
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);

  logic        rst_m_r;      // Reset release, first stage
  logic        rst_sync_n;   // Reset release, safe copy
  logic [1:0]  strap_m_r;    // Strap pins, first stage
  logic [1:0]  strap_r;      // Strap pins, safe copy
  logic        scl_lvl;      // Synchronised clock line
  logic        scl_rise;     // Clock line rising
  logic        scl_fall;     // Clock line falling
  logic        sda_lvl;      // Synchronised data line
  logic        sda_rise;     // Data line rising
  logic        sda_fall;     // Data line falling
  twrp_state_t state_r;      // Transfer phase
  twrp_state_t state_nxt;    // Phase after acknowledge slot
  logic [3:0]  bit_cnt_r;    // Bits of current byte seen
  logic        ack_ph_r;     // Inside acknowledge slot
  logic [7:0]  shift_r;      // Received byte
  logic [7:0]  tx_r;         // Byte being sent
  logic [7:0]  ptr_r;        // Register pointer
  logic        rw_r;         // Direction of this transfer
  logic        mack_r;       // Master acknowledged last byte
  logic        oe_n_r;       // Data line enable, low drives
  logic [7:0]  wdata_r;      // Write data to register file
  logic        wr_r;         // Write strobe
  logic        rd_r;         // Read strobe

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r    <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_m_r    <= 1'b1;
      rst_sync_n <= rst_m_r;
    end
  end

  // Strap pins pass two flops like any other pin
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      strap_m_r <= 2'h0;
      strap_r   <= 2'h0;
    end else begin
      strap_m_r <= slave_addr_select_pins;
      strap_r   <= strap_m_r;
    end
  end

  // Clock line synchroniser
  twrp_line_sync u_scl (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_n),
    .line_i     (scl_i),
    .level      (scl_lvl),
    .rise       (scl_rise),
    .fall       (scl_fall)
  );

  // Data line synchroniser
  twrp_line_sync u_sda (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_n),
    .line_i     (sda_i),
    .level      (sda_lvl),
    .rise       (sda_rise),
    .fall       (sda_fall)
  );

  // Bus conditions
  wire start_ev = scl_lvl & sda_fall;
  wire stop_ev  = scl_lvl & sda_rise;
  wire active   = (state_r != TWRP_IDLE) && (state_r != TWRP_IGNORE);
  // Byte complete, acknowledge slot begins
  wire dec_ev   = active & scl_fall & ~ack_ph_r &
                  (bit_cnt_r == TWRP_BYTE_BITS);
  // Acknowledge slot ends
  wire end_ev   = active & scl_fall & ack_ph_r;
  // Outgoing bit shift inside a read byte
  wire tx_ev    = (state_r == TWRP_RDATA) & scl_fall & ~ack_ph_r &
                  (bit_cnt_r != TWRP_BYTE_BITS);

  // Own address from fixed bits and straps
  wire [6:0] own_addr = {TWRP_ADDR_HI, strap_r};
  wire addr_match = (shift_r[7:1] == own_addr);
  wire ptr_ok     = (shift_r <= TWRP_REG_TOP);
  // Saturating pointer step
  wire [7:0] ptr_inc = (ptr_r >= TWRP_REG_TOP) ? TWRP_REG_TOP :
                       ptr_r + 8'h01;

  // Phase chosen at the end of the acknowledge slot
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TWRP_ADDR:  state_nxt = rw_r ? TWRP_RDATA : TWRP_PTR;
      TWRP_PTR:   state_nxt = TWRP_WDATA;
      TWRP_WDATA: state_nxt = TWRP_WDATA;
      TWRP_RDATA: state_nxt = mack_r ? TWRP_RDATA : TWRP_IGNORE;
      default:    state_nxt = state_r;
    endcase
  end

  // Phase and bit counting
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r   <= TWRP_IDLE;
      bit_cnt_r <= TWRP_BIT_ZERO;
      ack_ph_r  <= 1'b0;
    end else if (stop_ev) begin
      state_r   <= TWRP_IDLE;
      ack_ph_r  <= 1'b0;
    end else if (start_ev) begin
      state_r   <= TWRP_ADDR;
      bit_cnt_r <= TWRP_BIT_ZERO;
      ack_ph_r  <= 1'b0;
    end else if (dec_ev) begin
      ack_ph_r  <= 1'b1;
      // Mismatch or bad base: go quiet until next start
      if ((state_r == TWRP_ADDR && !addr_match) ||
          (state_r == TWRP_PTR && !ptr_ok)) begin
        state_r <= TWRP_IGNORE;
      end
    end else if (end_ev) begin
      ack_ph_r  <= 1'b0;
      bit_cnt_r <= TWRP_BIT_ZERO;
      state_r   <= state_nxt;
    end else if (active && scl_rise && !ack_ph_r) begin
      bit_cnt_r <= bit_cnt_r + TWRP_BIT_ONE;
    end
  end

  // Received byte, sampled on clock high, first bit lands on top
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      shift_r <= 8'h00;
    end else if (active && scl_rise && !ack_ph_r) begin
      shift_r <= {shift_r[6:0], sda_lvl};
    end
  end

  // Master acknowledge, sampled in the slot of a read byte
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mack_r <= 1'b0;
    end else if (state_r == TWRP_RDATA && ack_ph_r && scl_rise) begin
      mack_r <= ~sda_lvl;
    end
  end

  // Direction bit of the address byte
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rw_r <= 1'b0;
    end else if (dec_ev && state_r == TWRP_ADDR && addr_match) begin
      rw_r <= shift_r[TWRP_RW_POS];
    end
  end

  // Register pointer: load, write step, read step
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ptr_r <= TWRP_PTR_RST;
    end else if (dec_ev && state_r == TWRP_PTR && ptr_ok) begin
      ptr_r <= shift_r;
    end else if (end_ev && state_r == TWRP_WDATA) begin
      ptr_r <= ptr_inc;
    end else if (dec_ev && state_r == TWRP_RDATA) begin
      ptr_r <= ptr_inc;
    end
  end

  // Write strobe with data at the current pointer
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wdata_r <= 8'h00;
      wr_r    <= 1'b0;
    end else begin
      wr_r <= dec_ev && state_r == TWRP_WDATA;
      if (dec_ev && state_r == TWRP_WDATA) begin
        wdata_r <= shift_r;
      end
    end
  end

  // Load of a byte to send and its read strobe
  wire load_tx = end_ev && (state_nxt == TWRP_RDATA);
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_r <= 8'h00;
      rd_r <= 1'b0;
    end else begin
      rd_r <= load_tx;
      if (load_tx) begin
        tx_r <= {reg_rdata[6:0], 1'b0};
      end else if (tx_ev) begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Data line drive, changed on clock falling edges, released at start or stop
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      oe_n_r <= 1'b1;
    end else if (start_ev || stop_ev) begin
      oe_n_r <= 1'b1;
    end else if (dec_ev) begin
      // Ack on address match, valid base, or write data
      case (state_r)
        TWRP_ADDR:  oe_n_r <= ~addr_match;
        TWRP_PTR:   oe_n_r <= ~ptr_ok;
        TWRP_WDATA: oe_n_r <= 1'b0;
        default:    oe_n_r <= 1'b1;         // Master acks a read byte
      endcase
    end else if (load_tx) begin
      oe_n_r <= reg_rdata[7];
    end else if (end_ev) begin
      oe_n_r <= 1'b1;
    end else if (tx_ev) begin
      oe_n_r <= tx_r[7];
    end
  end

  // Outputs
  assign sda_o     = 1'b0;
  assign sda_oe_n  = oe_n_r;
  assign reg_addr  = ptr_r;
  assign reg_wdata = wdata_r;
  assign reg_wr    = wr_r;
  assign reg_rd    = rd_r;

  // Drive changes only follow a low clock line
  AST_DRIVE_LOW_CLK: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    ($changed(oe_n_r) && !$past(start_ev) && !$past(stop_ev))
      |-> !$past(scl_lvl))
    else $error("data line changed while clock high");

  AST_STOP_IDLE: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    stop_ev |=> (state_r == TWRP_IDLE) && oe_n_r)
    else $error("stop did not end transaction");

  AST_START_ADDR: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    (start_ev && !stop_ev) |=>
      (state_r == TWRP_ADDR) && (bit_cnt_r == TWRP_BIT_ZERO))
    else $error("start not taken");

  AST_PTR_SAT: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    ptr_r <= TWRP_REG_TOP)
    else $error("pointer beyond top register");

  AST_BASE_NACK: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    (dec_ev && state_r == TWRP_PTR && shift_r > TWRP_REG_TOP
      && !start_ev && !stop_ev)
      |=> oe_n_r && (state_r == TWRP_IGNORE) && $stable(ptr_r))
    else $error("bad base address acknowledged");

  AST_ADDR_ACK: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    (dec_ev && state_r == TWRP_ADDR && shift_r[7:1] == own_addr
      && !start_ev && !stop_ev) |=> !oe_n_r)
    else $error("own address not acknowledged");

  AST_ADDR_SILENT: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    (state_r == TWRP_IGNORE || state_r == TWRP_IDLE) |-> ##1 oe_n_r)
    else $error("data line driven while not addressed");

  AST_WRITE_STROBE: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    (dec_ev && state_r == TWRP_WDATA && !start_ev && !stop_ev)
      |=> reg_wr && (reg_wdata == $past(shift_r))
          && (reg_addr == $past(ptr_r)))
    else $error("write data or address wrong");

  AST_WRITE_STEP: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    (end_ev && state_r == TWRP_WDATA && !start_ev && !stop_ev)
      |=> ptr_r == $past(ptr_inc))
    else $error("write pointer did not step");

  AST_READ_END: assert property (
    @(posedge mclk) disable iff (!rst_sync_n)
    (end_ev && state_r == TWRP_RDATA && !mack_r
      && !start_ev && !stop_ev)
      |=> oe_n_r && (state_r == TWRP_IGNORE))
    else $error("read not ended on master no-ack");

endmodule
`default_nettype wire

// *** twrp_pkg.sv ***
// Shared constants and types for the two-wire register port
`default_nettype none
package twrp_pkg;

  // Fixed upper five bits of the seven-bit slave address
  localparam logic [4:0] TWRP_ADDR_HI   = 5'h13;
  // Highest register the pointer may reach
  localparam logic [7:0] TWRP_REG_TOP   = 8'h14;
  // Pointer value after reset
  localparam logic [7:0] TWRP_PTR_RST   = 8'h00;
  // Data bits in one byte
  localparam logic [3:0] TWRP_BYTE_BITS = 4'h8;
  // Bit counter value at the start of a byte
  localparam logic [3:0] TWRP_BIT_ZERO  = 4'h0;
  // Bit counter step
  localparam logic [3:0] TWRP_BIT_ONE   = 4'h1;
  // Position of the direction bit in the address byte
  localparam int         TWRP_RW_POS    = 0;
  // Idle level of a released bus line
  localparam logic       TWRP_LINE_IDLE = 1'b1;

  // Transfer phases of the port
  typedef enum logic [2:0] {
    TWRP_IDLE,
    TWRP_ADDR,
    TWRP_PTR,
    TWRP_WDATA,
    TWRP_RDATA,
    TWRP_IGNORE
  } twrp_state_t;

endpackage
`default_nettype wire

// *** twrp_line_sync.sv ***
// Two-flop synchroniser with edge detection for one bus line
`timescale 1ns/1ps
`default_nettype none
module twrp_line_sync
  import twrp_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_sync_n,
  // Raw line from the pin
  input  wire logic line_i,
  // Synchronised level and edge pulses
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_r;   // First stage, read only by the second
  logic sync_r;   // Second stage, safe level
  logic hist_r;   // Previous safe level

  // Synchroniser chain, idle high after reset
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta_r <= TWRP_LINE_IDLE;
      sync_r <= TWRP_LINE_IDLE;
      hist_r <= TWRP_LINE_IDLE;
    end else begin
      meta_r <= line_i;
      sync_r <= meta_r;
      hist_r <= sync_r;
    end
  end

  // Edges seen on the safe level
  assign level = sync_r;
  assign rise  = sync_r & ~hist_r;
  assign fall  = ~sync_r & hist_r;

endmodule
`default_nettype wire

// *** twrp_master.sv ***
// Behavioural two-wire bus master that drives the port's serial pins
`timescale 1ns/1ps
`default_nettype none
module twrp_master (
  // Bench clock
  input  wire logic mclk,
  // Resolved data line
  input  wire logic sda,
  // Driven clock line and data pull-down
  output logic      scl,
  output logic      sda_low
);
  // Idle bus, both lines released
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  // Wait some falls of the bench clock
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One bit slot: 5 clocks low, 3 high, data set mid-low
  task automatic bit_slot(input logic b, output logic s);
    w(2);
    sda_low = ~b;
    w(3);
    scl = 1'b1;
    w(2);
    s = sda;
    w(1);
    scl = 1'b0;
  endtask
  // Start or repeated start, data falls while clock high
  task automatic start();
    if (scl === 1'b0) begin
      w(2);
      sda_low = 1'b0;
      w(3);
      scl = 1'b1;
      w(2);
    end
    sda_low = 1'b1;
    w(3);
    scl = 1'b0;
  endtask
  // Stop, data rises while clock high, then clock stands still
  task automatic stop();
    w(2);
    sda_low = 1'b1;
    w(3);
    scl = 1'b1;
    w(3);
    sda_low = 1'b0;
    w(4);
  endtask
  // Byte out, top bit first, returns the ack level
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], s);
    bit_slot(1'b1, ack);
  endtask
  // Byte in, top bit first, then ack or no-ack
  task automatic get_byte(input logic ack_low, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      b[i] = s;
    end
    bit_slot(~ack_low, s);
  endtask
endmodule
`default_nettype wire

// *** twrp_port_bench.sv ***
// Self-checking bench for the two-wire register port
`timescale 1ns/1ps
`default_nettype none
module twrp_port_bench import twrp_pkg::*;;
  logic        mclk = 1'b0;  // Bench clock
  logic        rst_n = 1'b0; // Reset
  logic [1:0]  straps = 2'h0; // Address straps
  wire         scl;          // Bus clock
  wire         sda;          // Resolved data line
  wire         sda_low;      // Master pull-down
  logic        sda_o;        // Port data out
  logic        sda_oe_n;     // Port drive enable
  logic [7:0]  reg_addr;     // Register pointer
  logic [7:0]  reg_wdata;    // Write data
  logic        reg_wr;       // Write pulse
  logic        reg_rd;       // Read pulse
  wire  [7:0]  reg_rdata;    // Read data
  logic [7:0]  regs [0:20];  // Register file model
  logic [7:0]  exp_reg [0:20]; // Expected contents
  logic [15:0] wr_q [$];     // Expected writes
  logic [15:0] exp_w;        // Oldest expected write
  logic        scl_q = 1'b1; // Clock one cycle ago
  logic        oe_q = 1'b1;  // Enable one cycle ago
  int          rd_count = 0; // Read pulses seen
  int          err_count = 0;
  int          comparisons = 0;
  // Clock at 20 MHz
  always #25 mclk = ~mclk;
  // Pull-up with two open-drain drivers
  assign sda = ~(sda_low | (sda_oe_n === 1'b0));
  assign reg_rdata = (reg_addr <= TWRP_REG_TOP) ? regs[reg_addr] : 8'hFF;
  twrp_master m_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  twrp_port dut_u (
    .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .slave_addr_select_pins(straps),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // Shared mismatch report
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Compare one bit
  task automatic chk_bit(input logic g, input logic e);
    cmp({15'h0, g}, {15'h0, e});
  endtask
  // Compare one byte
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    cmp({8'h0, g}, {8'h0, e});
  endtask
  // Compare one register write, address and data
  task automatic chk_wr(input logic [15:0] g, input logic [15:0] e);
    cmp(g, e);
  endtask
  // Watch writes, read pulses and data changes in clock high
  always @(posedge mclk) begin
    if (reg_wr === 1'b1) begin
      if (reg_addr <= TWRP_REG_TOP) regs[reg_addr] <= reg_wdata;
      // Unexpected write compares against its own inverse
      exp_w = wr_q.size() ? wr_q.pop_front() : ~{reg_addr, reg_wdata};
      chk_wr({reg_addr, reg_wdata}, exp_w);
    end
    if (reg_rd === 1'b1) rd_count++;
    if (sda_oe_n === 1'b0) chk_bit(sda_o, 1'b0);
    if (scl_q && scl && rst_n) chk_bit(sda_oe_n, oe_q);
    scl_q <= scl;
    oe_q  <= sda_oe_n;
  end
  // Pointer after i bytes, held at the top register
  function automatic logic [7:0] sat(input int a);
    return (a > 20) ? TWRP_REG_TOP : 8'(a);
  endfunction
  // Address-only frame, expected ack level given
  task automatic addr_seq(input logic [6:0] adr, input logic e);
    logic a;
    m_u.start();
    m_u.put_byte({adr, 1'b0}, a);
    chk_bit(a, e);
    m_u.stop();
  endtask
  // Write n random bytes from a base
  task automatic wr_seq(input logic [7:0] base, input int n);
    logic a;
    logic [7:0] d;
    logic [7:0] p;
    m_u.start();
    m_u.put_byte({TWRP_ADDR_HI, straps, 1'b0}, a);
    chk_bit(a, 1'b0);
    m_u.put_byte(base, a);
    chk_bit(a, base > TWRP_REG_TOP);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      p = sat(base + i);
      if (base <= TWRP_REG_TOP) begin
        wr_q.push_back({p, d});
        exp_reg[p] = d;
      end
      m_u.put_byte(d, a);
      chk_bit(a, base > TWRP_REG_TOP);
    end
    // Ack is let go a few clocks after the clock line falls
    m_u.w(3);
    chk_bit(sda, 1'b1);
    m_u.stop();
    chk_byte(8'(wr_q.size()), 8'h00);
  endtask
  // Set base, repeated start, read n bytes, no-ack the last
  task automatic rd_seq(input logic [7:0] base, input int n);
    logic a;
    logic [7:0] d;
    int r0;
    m_u.start();
    m_u.put_byte({TWRP_ADDR_HI, straps, 1'b0}, a);
    m_u.put_byte(base, a);
    chk_bit(a, 1'b0);
    m_u.start();
    m_u.put_byte({TWRP_ADDR_HI, straps, 1'b1}, a);
    chk_bit(a, 1'b0);
    r0 = rd_count;
    for (int i = 0; i < n; i++) begin
      m_u.get_byte(i < n - 1, d);
      chk_byte(d, exp_reg[sat(base + i)]);
    end
    chk_bit(sda, 1'b1);
    chk_byte(8'(rd_count - r0), 8'(n));
    m_u.stop();
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons=%0d errors=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog, well beyond the expected run
  initial begin
    #2000000;
    err_count++;
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, 0, 1);
    tally_and_finish();
  end
  // Main sequence
  initial begin
    logic [7:0] b;
    void'($urandom(32'hbca0));
    for (int i = 0; i <= 20; i++) begin
      regs[i] = 8'($urandom);
      exp_reg[i] = regs[i];
    end
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    wr_seq(8'h12, 4);
    rd_seq(8'h12, 4);
    rd_seq(8'h00, 3);
    $display("test saturate done");
    for (int s = 0; s < 4; s++) begin
      straps = 2'(s);
      addr_seq({TWRP_ADDR_HI, ~straps}, 1'b1);
      addr_seq({~TWRP_ADDR_HI, straps}, 1'b1);
      b = 8'($urandom % 21);
      wr_seq(b, 2);
      rd_seq(b, 2);
    end
    $display("test straps done");
    wr_seq(8'h15, 1);
    wr_seq(8'h15 + 8'($urandom % 235), 1);
    wr_seq(8'h14, 1);
    rd_seq(8'h14, 2);
    $display("test range done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
